/* isec_pkg.sv */
// Constants and types for the idle speed effort controller
// Overview of operation
// - Stopped or cranking: command fully open effort
// - Stepper: run full travel open first
// - All gains zero means open loop only
// - Base from coolant table; invalid adds cold
// - Post-start extra decays linearly to zero
// - No closed loop while post-start decays
// - Air conditioning effort added on top
// - Electrical load efforts added when load active
// - Low battery effort below threshold voltage
// - Motion opening effort when vehicle moving
// - Optional air temperature correction of effort
// - Closed loop needs all three conditions
// - Drivetrain idle: clutch, or opener and stationary
// - Speed band: below target plus band, or timeout
// - Air conditioning band while air conditioning on
// - Time conditions; timeout satisfies speed band
// - Effort is duty percent or step position
// - Clamp effort between min and max, except when stopped or cranking
// - Two-coil pattern keeps two windings on
// - Hold each step at least step period
// - At travel end, repeat step periodically
package isec_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int EW = 16;
   localparam int TEMP_PTS = 8;
   localparam int STEP_PERIOD_MS = 11;
   localparam int STEP_PERIOD_CYC = (CLK_HZ / 1000) * STEP_PERIOD_MS;
   localparam int END_REPEAT_MS = 3000;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam logic [15:0] LOW_BATT_MV = 16'd12000;
   localparam logic [6:0] DUTY_FULL = 7'd100;
   // Register indices
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BASE0 = 8'h01;
   localparam logic [7:0] REG_COLD = 8'h09;
   localparam logic [7:0] REG_POST = 8'h0a;
   localparam logic [7:0] REG_POST_MS = 8'h0b;
   localparam logic [7:0] REG_AC = 8'h0c;
   localparam logic [7:0] REG_ELEC0 = 8'h0d;
   localparam logic [7:0] REG_BATT = 8'h10;
   localparam logic [7:0] REG_MOTION = 8'h11;
   localparam logic [7:0] REG_MIN = 8'h12;
   localparam logic [7:0] REG_MAX = 8'h13;
   localparam logic [7:0] REG_BAND = 8'h14;
   localparam logic [7:0] REG_BAND_AC = 8'h15;
   localparam logic [7:0] REG_TIMEOUT_MS = 8'h16;
   localparam logic [7:0] REG_GAINS = 8'h17;
   localparam logic [7:0] REG_AIRCORR = 8'h18;
   localparam logic [7:0] REG_TRAVEL = 8'h19;
   localparam logic [7:0] REG_STATUS = 8'h1a;
   localparam logic [7:0] REG_EFFORT = 8'h1b;
   // Control bits
   localparam int CTRL_STEPPER = 0;
   localparam int CTRL_PULSE = 1;
   localparam int CTRL_MOTION_EN = 2;
   localparam int CTRL_AIR_EN = 3;
   typedef enum logic [1:0] {ISEC_ST_HOME, ISEC_ST_RUN} isec_mode_t;
endpackage : isec_pkg

/* isec_top.sv */
// Idle speed effort computation, closed loop gate and stepper drive
`timescale 1ns/100ps
module isec_top
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Engine state pins
   input wire logic engine_stopped_i,
   input wire logic cranking_i,
   input wire logic throttle_closed_i,
   input wire logic clutch_neutral_i,
   input wire logic ac_on_i,
   input wire logic [2:0] elec_load_i,
   // Measurements from logic on this clock
   input wire logic coolant_valid_i,
   input wire logic [2:0] coolant_idx_i,
   input wire logic [15:0] batt_mv_i,
   input wire logic [15:0] vehicle_speed_measure_i,
   input wire logic [15:0] rpm_i,
   input wire logic [15:0] target_rpm_i,
   input wire logic signed [7:0] air_temp_i,
   input wire logic signed [15:0] pid_corr_i,
   // Actuator outputs
   output logic closed_loop_o,
   output logic [15:0] effort_o,
   output logic [3:0] stepper_o
);
   logic stop_s1, stop_s2, crank_s1, crank_s2, thr_s1, thr_s2;
   logic clu_s1, clu_s2, ac_s1, ac_s2;
   logic [2:0] el_s1, el_s2;
   logic [15:0] ctrl_r, cold_r, post_r, post_ms_r, ac_eff_r, batt_r, motion_r;
   logic [15:0] min_r, max_r, band_r, band_ac_r, timeout_ms_r, gains_r;
   logic [15:0] aircorr_r, travel_r;
   logic [15:0] base_r [isec_pkg::TEMP_PTS];
   logic [15:0] elec_r [3];
   logic [15:0] post_left_r, cond_ms_r, ms_cnt_r;
   logic ms_tick;
   logic running_r;
   logic [15:0] pos_r, home_cnt_r;
   logic [23:0] step_cnt_r, end_cnt_r;
   logic [1:0] phase_r;
   isec_pkg::isec_mode_t mode_r;
   logic [19:0] ol_sum;
   logic signed [20:0] tot;
   logic [15:0] effort_nxt;
   logic moving, drive_idle, band_ok, others_ok, cl_ok;

   // Pins cross into the clock domain
   always_ff @(posedge clk_sys_i)
   begin
      stop_s1 <= engine_stopped_i;
      stop_s2 <= stop_s1;
      crank_s1 <= cranking_i;
      crank_s2 <= crank_s1;
      thr_s1 <= throttle_closed_i;
      thr_s2 <= thr_s1;
      clu_s1 <= clutch_neutral_i;
      clu_s2 <= clu_s1;
      ac_s1 <= ac_on_i;
      ac_s2 <= ac_s1;
      el_s1 <= elec_load_i;
      el_s2 <= el_s1;
   end

   // Configuration writes
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         ctrl_r <= 16'h0000;
         cold_r <= 16'h0000;
         post_r <= 16'h0000;
         post_ms_r <= 16'h0000;
         ac_eff_r <= 16'h0000;
         batt_r <= 16'h0000;
         motion_r <= 16'h0000;
         min_r <= 16'h0000;
         max_r <= 16'h0064;
         band_r <= 16'h0000;
         band_ac_r <= 16'h0000;
         timeout_ms_r <= 16'h0000;
         gains_r <= 16'h0000;
         aircorr_r <= 16'h0000;
         travel_r <= 16'h0000;
         for (int i = 0; i < isec_pkg::TEMP_PTS; i++)
            base_r[i] <= 16'h0000;
         for (int i = 0; i < 3; i++)
            elec_r[i] <= 16'h0000;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == isec_pkg::REG_CTRL)
            ctrl_r <= reg_wdata_i;
         else if (reg_addr_i >= isec_pkg::REG_BASE0 && reg_addr_i < isec_pkg::REG_COLD)
            base_r[3'(reg_addr_i - isec_pkg::REG_BASE0)] <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_COLD)
            cold_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_POST)
            post_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_POST_MS)
            post_ms_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_AC)
            ac_eff_r <= reg_wdata_i;
         else if (reg_addr_i >= isec_pkg::REG_ELEC0 && reg_addr_i < isec_pkg::REG_BATT)
            elec_r[2'(reg_addr_i - isec_pkg::REG_ELEC0)] <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_BATT)
            batt_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_MOTION)
            motion_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_MIN)
            min_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_MAX)
            max_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_BAND)
            band_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_BAND_AC)
            band_ac_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_TIMEOUT_MS)
            timeout_ms_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_GAINS)
            gains_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_AIRCORR)
            aircorr_r <= reg_wdata_i;
         else if (reg_addr_i == isec_pkg::REG_TRAVEL)
            travel_r <= reg_wdata_i;
      end
   end

   // Read port, unmapped reads zero
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         reg_rdata_o <= 16'h0000;
      else if (reg_rd_i)
      begin
         if (reg_addr_i == isec_pkg::REG_CTRL)
            reg_rdata_o <= ctrl_r;
         else if (reg_addr_i >= isec_pkg::REG_BASE0 && reg_addr_i < isec_pkg::REG_COLD)
            reg_rdata_o <= base_r[3'(reg_addr_i - isec_pkg::REG_BASE0)];
         else if (reg_addr_i == isec_pkg::REG_STATUS)
            reg_rdata_o <= {12'h000, mode_r == isec_pkg::ISEC_ST_HOME, running_r,
                            post_left_r != 16'h0000, closed_loop_o};
         else if (reg_addr_i == isec_pkg::REG_EFFORT)
            reg_rdata_o <= effort_o;
         else if (reg_addr_i == isec_pkg::REG_TRAVEL)
            reg_rdata_o <= travel_r;
         else if (reg_addr_i == isec_pkg::REG_MIN)
            reg_rdata_o <= min_r;
         else if (reg_addr_i == isec_pkg::REG_MAX)
            reg_rdata_o <= max_r;
         else
            reg_rdata_o <= 16'h0000;
      end
   end

   // Millisecond tick
   assign ms_tick = (ms_cnt_r == 16'(isec_pkg::MS_CYC - 1));
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || ms_tick)
         ms_cnt_r <= 16'h0000;
      else
         ms_cnt_r <= ms_cnt_r + 16'h0001;
   end

   // Post-start decay, remaining milliseconds
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         running_r <= 1'b0;
         post_left_r <= 16'h0000;
      end
      else if (stop_s2 || crank_s2)
      begin
         running_r <= 1'b0;
         post_left_r <= 16'h0000;
      end
      else if (!running_r)
      begin
         running_r <= 1'b1;
         post_left_r <= post_ms_r;
      end
      else if (ms_tick && post_left_r != 16'h0000)
         post_left_r <= post_left_r - 16'h0001;
   end

   assign moving = (vehicle_speed_measure_i != 16'h0000);
   assign drive_idle = clu_s2 || (ctrl_r[isec_pkg::CTRL_MOTION_EN] && !moving);
   assign others_ok = thr_s2 && drive_idle && running_r && post_left_r == 16'h0000;

   // Time the other conditions held
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || !others_ok)
         cond_ms_r <= 16'h0000;
      else if (ms_tick && cond_ms_r != 16'hffff)
         cond_ms_r <= cond_ms_r + 16'h0001;
   end

   always_comb
   begin
      logic [16:0] lim;
      lim = {1'b0, target_rpm_i} + {1'b0, (ac_s2 ? band_ac_r : band_r)};
      band_ok = ({1'b0, rpm_i} < lim) || (cond_ms_r >= timeout_ms_r);
   end
   assign cl_ok = others_ok && band_ok && gains_r != 16'h0000;

   // Open loop sum and clamp
   always_comb
   begin
      logic [35:0] prod;
      logic [19:0] dec;
      prod = 36'h000000000;
      dec = 20'h00000;
      if (post_ms_r != 16'h0000)
         dec = 20'(({16'h0000, post_r} * {16'h0000, post_left_r}) / {16'h0000, post_ms_r});
      ol_sum = {4'h0, base_r[coolant_idx_i]} + dec;
      if (!coolant_valid_i)
         ol_sum = ol_sum + {4'h0, cold_r};
      // Any load input adds all three efforts
      if (el_s2 != 3'b000)
         for (int i = 0; i < 3; i++)
            ol_sum = ol_sum + {4'h0, elec_r[i]};
      if (batt_mv_i < isec_pkg::LOW_BATT_MV)
         ol_sum = ol_sum + {4'h0, batt_r};
      if (ctrl_r[isec_pkg::CTRL_MOTION_EN] && moving)
         ol_sum = ol_sum + {4'h0, motion_r};
      // Scale in 1/256 per degree, applied before the A/C addition
      prod = 36'($signed({1'b0, ol_sum}) * ($signed(aircorr_r) * air_temp_i));
      if (ctrl_r[isec_pkg::CTRL_AIR_EN])
         ol_sum = 20'($signed({1'b0, ol_sum}) + $signed(prod[35:8]));
      if (ac_s2)
         ol_sum = ol_sum + {4'h0, ac_eff_r};
      tot = $signed({1'b0, ol_sum}) + (cl_ok ? 21'(pid_corr_i) : 21'sd0);
      if (stop_s2 || crank_s2)
         effort_nxt = ctrl_r[isec_pkg::CTRL_STEPPER] ? travel_r : 16'(isec_pkg::DUTY_FULL);
      else if (tot < $signed({5'h00, min_r}))
         effort_nxt = min_r;
      else if (tot > $signed({5'h00, max_r}))
         effort_nxt = max_r;
      else
         effort_nxt = tot[15:0];
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         effort_o <= 16'h0000;
         closed_loop_o <= 1'b0;
      end
      else
      begin
         effort_o <= effort_nxt;
         closed_loop_o <= cl_ok;
      end
   end

   // Stepper drive; position unknown until homed open
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         mode_r <= isec_pkg::ISEC_ST_HOME;
         pos_r <= 16'h0000;
         home_cnt_r <= 16'h0000;
         phase_r <= 2'b00;
         step_cnt_r <= 24'h000000;
         end_cnt_r <= 24'h000000;
      end
      else if (step_cnt_r < 24'(isec_pkg::STEP_PERIOD_CYC - 1))
         step_cnt_r <= step_cnt_r + 24'h000001;
      else if (ctrl_r[isec_pkg::CTRL_STEPPER])
      begin
         case (mode_r)
            isec_pkg::ISEC_ST_HOME:
            begin
               step_cnt_r <= 24'h000000;
               if (home_cnt_r < travel_r)
               begin
                  home_cnt_r <= home_cnt_r + 16'h0001;
                  phase_r <= phase_r + 2'b01;
               end
               else
               begin
                  pos_r <= travel_r;
                  mode_r <= isec_pkg::ISEC_ST_RUN;
               end
            end
            isec_pkg::ISEC_ST_RUN:
            begin
               if (effort_o > pos_r)
               begin
                  step_cnt_r <= 24'h000000;
                  pos_r <= pos_r + 16'h0001;
                  phase_r <= phase_r + 2'b01;
               end
               else if (effort_o < pos_r)
               begin
                  step_cnt_r <= 24'h000000;
                  pos_r <= pos_r - 16'h0001;
                  phase_r <= phase_r - 2'b01;
               end
               else if (effort_o == 16'h0000 || effort_o == travel_r)
               begin
                  if (end_cnt_r >= 24'(isec_pkg::END_REPEAT_MS))
                  begin
                     end_cnt_r <= 24'h000000;
                     step_cnt_r <= 24'h000000;
                     phase_r <= (effort_o == 16'h0000) ? phase_r - 2'b01 : phase_r + 2'b01;
                  end
                  else if (ms_tick) // Counted in ms; cycles would overflow 24 bits
                     end_cnt_r <= end_cnt_r + 24'h000001;
               end
            end
            default:
               mode_r <= isec_pkg::ISEC_ST_HOME;
         endcase
      end
   end

   // Coil patterns, active high
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || !ctrl_r[isec_pkg::CTRL_STEPPER])
         stepper_o <= 4'h0;
      else if (ctrl_r[isec_pkg::CTRL_PULSE])
         stepper_o <= 4'h1 << phase_r;
      else
      begin
         case (phase_r)
            2'd0: stepper_o <= 4'hc;
            2'd1: stepper_o <= 4'ha;
            2'd2: stepper_o <= 4'h3;
            default: stepper_o <= 4'h5;
         endcase
      end
   end
endmodule // isec_top

/* isec_checker.sv */
// Port checker for the idle speed effort controller, bound to its top
`timescale 1ns/100ps
module isec_checker
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   // Engine pins
   input wire logic engine_stopped_i,
   input wire logic cranking_i,
   input wire logic throttle_closed_i,
   input wire logic clutch_neutral_i,
   // Actuator side
   input wire logic closed_loop_o,
   input wire logic [15:0] effort_o,
   input wire logic [3:0] stepper_o
);
   logic step_r, pulse_r, motion_r, gz_r, post_r;
   // Shadow settings, so properties know the mode without peeking inside
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         {motion_r, pulse_r, step_r, post_r} <= 4'h0;
         gz_r <= 1'b1;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == isec_pkg::REG_CTRL)
            {motion_r, pulse_r, step_r} <= reg_wdata_i[2:0];
         if (reg_addr_i == isec_pkg::REG_GAINS)
            gz_r <= (reg_wdata_i == 16'h0000);
         if (reg_addr_i == isec_pkg::REG_POST_MS)
            post_r <= (reg_wdata_i != 16'h0000);
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h1b |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_effort_readback: assert property ((reg_rd_i && reg_addr_i == isec_pkg::REG_EFFORT)
      ##1 $stable(effort_o) |-> reg_rdata_o == effort_o) else $error("effort readback wrong");
   a_stopped_open: assert property ((engine_stopped_i && !step_r) [*5] |-> effort_o == 16'h0064)
      else $error("stopped engine not fully open");
   a_gains_zero: assert property (gz_r && $past(gz_r, 3) |-> !closed_loop_o)
      else $error("closed loop with zero gains");
   a_throttle_gate: assert property (!throttle_closed_i [*5] |-> !closed_loop_o)
      else $error("closed loop with throttle open");
   a_drive_idle_gate: assert property ((!clutch_neutral_i && !motion_r) [*5] |-> !closed_loop_o)
      else $error("closed loop without drivetrain idle");
   a_post_no_loop: assert property ($fell(engine_stopped_i || cranking_i) && post_r
      |-> ##5 !closed_loop_o [*8]) else $error("closed loop during post start decay");
   a_hold_pattern: assert property (!pulse_r && stepper_o != 4'h0
      |-> stepper_o inside {4'hc, 4'ha, 4'h3, 4'h5}) else $error("two coil pattern wrong");
   cover property ($rose(closed_loop_o));
   cover property ($fell(engine_stopped_i || cranking_i));
   cover property (reg_rd_i && reg_addr_i > 8'h1b);
endmodule // isec_checker

bind isec_top isec_checker isec_checker_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .engine_stopped_i(engine_stopped_i),
   .cranking_i(cranking_i), .throttle_closed_i(throttle_closed_i),
   .clutch_neutral_i(clutch_neutral_i), .closed_loop_o(closed_loop_o),
   .effort_o(effort_o), .stepper_o(stepper_o));

/* isec_valve_model.sv */
// Idle air valve model: follows solenoid duty and counts stepper coil changes
`timescale 1ns/100ps
module isec_valve_model
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Drive from the controller
   input wire logic [15:0] effort_i,
   input wire logic [3:0] coil_i,
   // Valve state
   output logic [15:0] duty_o,
   output logic [15:0] pos_o
);
   logic [3:0] last_r;
   // Position counts every change to a nonzero coil pattern upward and saturates at 16'hffff, not at a travel stop
   always_ff @(posedge clk_sys_i)
   begin
      last_r <= coil_i;
      duty_o <= effort_i;
      if (!rstn_i)
         pos_o <= 16'h0000;
      else if (coil_i != last_r && coil_i != 4'h0 && pos_o != 16'hffff)
         pos_o <= pos_o + 16'h0001;
   end
endmodule // isec_valve_model

/* isec_top_bench.sv */
// Self-checking bench for the idle speed effort controller
`timescale 1ns/100ps
module isec_top_bench;
   logic clk_sys_i, rstn_i, reg_wr_i, reg_rd_i, engine_stopped_i, cranking_i;
   logic throttle_closed_i, clutch_neutral_i, ac_on_i, coolant_valid_i, closed_loop_o;
   logic [2:0] elec_load_i, coolant_idx_i;
   logic [3:0] stepper_o;
   logic [7:0] reg_addr_i;
   logic signed [7:0] air_temp_i;
   logic signed [15:0] pid_corr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, batt_mv_i, vehicle_speed_measure_i, rpm_i;
   logic [15:0] target_rpm_i, effort_o, duty, pos;
   int err_count, checks_done;
   isec_top isec_top_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .engine_stopped_i(engine_stopped_i), .cranking_i(cranking_i),
      .throttle_closed_i(throttle_closed_i), .clutch_neutral_i(clutch_neutral_i),
      .ac_on_i(ac_on_i), .elec_load_i(elec_load_i), .coolant_valid_i(coolant_valid_i),
      .coolant_idx_i(coolant_idx_i), .batt_mv_i(batt_mv_i),
      .vehicle_speed_measure_i(vehicle_speed_measure_i), .rpm_i(rpm_i),
      .target_rpm_i(target_rpm_i), .air_temp_i(air_temp_i), .pid_corr_i(pid_corr_i),
      .closed_loop_o(closed_loop_o), .effort_o(effort_o), .stepper_o(stepper_o));
   isec_valve_model isec_valve_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .effort_i(effort_o), .coil_i(stepper_o), .duty_o(duty), .pos_o(pos));
   task automatic stop_test;
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", exp, reg_rdata_o);
      @(posedge clk_sys_i);
   endtask
   // Inputs cross two sync stages and a register before outputs move
   task automatic eff(input logic [15:0] exp, input logic cl);
      repeat (6) @(posedge clk_sys_i);
      #1 chk("effort", exp, effort_o);
      chk("closed_loop", {15'h0000, cl}, {15'h0000, closed_loop_o});
      @(posedge clk_sys_i);
   endtask
   initial
   begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // Whole sequence needs about 36300 cycles
   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      err_count++;
      stop_test();
   end
   initial
   begin
      err_count = 0;
      checks_done = 0;
      rstn_i <= 1'b0;
      {reg_wr_i, reg_rd_i, cranking_i, ac_on_i, throttle_closed_i} <= 5'h00;
      {engine_stopped_i, clutch_neutral_i, coolant_valid_i} <= 3'h7;
      {elec_load_i, coolant_idx_i} <= 6'h00;
      reg_addr_i <= 8'h00;
      reg_wdata_i <= 16'h0000;
      batt_mv_i <= 16'h3a98;
      vehicle_speed_measure_i <= 16'h0000;
      rpm_i <= 16'h0320;
      target_rpm_i <= 16'h0384;
      air_temp_i <= 8'sh00;
      pid_corr_i <= 16'sh0000;
      repeat (6) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(posedge clk_sys_i);
      rd(8'h40, 16'h0000);
      eff(16'h0064, 1'b0);
      wr(isec_pkg::REG_EFFORT, 16'h1234);
      rd(isec_pkg::REG_EFFORT, 16'h0064);
      for (int k = 0; k < 8; k++)
         wr(isec_pkg::REG_BASE0 + 8'(k), 16'h0010 + 16'(k));
      for (int k = 0; k < 3; k++)
         wr(isec_pkg::REG_ELEC0 + 8'(k), 16'h0001 + 16'(k));
      wr(isec_pkg::REG_COLD, 16'h0005);
      wr(isec_pkg::REG_POST, 16'h0014);
      wr(isec_pkg::REG_POST_MS, 16'h0002);
      wr(isec_pkg::REG_AC, 16'h0007);
      wr(isec_pkg::REG_BATT, 16'h0008);
      wr(isec_pkg::REG_MOTION, 16'h0009);
      wr(isec_pkg::REG_BAND, 16'h0064);
      wr(isec_pkg::REG_BAND_AC, 16'h00c8);
      wr(isec_pkg::REG_TIMEOUT_MS, 16'h0001);
      wr(isec_pkg::REG_TRAVEL, 16'h00c8);
      wr(isec_pkg::REG_GAINS, 16'h0001);
      engine_stopped_i <= 1'b0;
      cranking_i <= 1'b1;
      eff(16'h0064, 1'b0);
      cranking_i <= 1'b0;
      throttle_closed_i <= 1'b1;
      eff(16'h0024, 1'b0);
      repeat (15000) @(posedge clk_sys_i);
      eff(16'h001a, 1'b0);
      repeat (10000) @(posedge clk_sys_i);
      eff(16'h0010, 1'b1);
      pid_corr_i <= 16'sh0005;
      eff(16'h0015, 1'b1);
      throttle_closed_i <= 1'b0;
      eff(16'h0010, 1'b0);
      throttle_closed_i <= 1'b1;
      rpm_i <= 16'h03e7;
      eff(16'h0015, 1'b1);
      rpm_i <= 16'h03e8;
      eff(16'h0010, 1'b0);
      ac_on_i <= 1'b1;
      eff(16'h001c, 1'b1);
      ac_on_i <= 1'b0;
      repeat (11000) @(posedge clk_sys_i);
      eff(16'h0015, 1'b1);
      clutch_neutral_i <= 1'b0;
      eff(16'h0010, 1'b0);
      rpm_i <= 16'h0320;
      wr(isec_pkg::REG_CTRL, 16'h0004);
      eff(16'h0015, 1'b1);
      vehicle_speed_measure_i <= 16'h0001;
      eff(16'h0019, 1'b0);
      clutch_neutral_i <= 1'b1;
      wr(isec_pkg::REG_CTRL, 16'h0000);
      wr(isec_pkg::REG_GAINS, 16'h0000);
      eff(16'h0010, 1'b0);
      vehicle_speed_measure_i <= 16'h0000;
      for (int k = 0; k < 8; k++)
      begin
         coolant_idx_i <= 3'(k);
         eff(16'h0010 + 16'(k), 1'b0);
      end
      coolant_idx_i <= 3'h0;
      coolant_valid_i <= 1'b0;
      eff(16'h0015, 1'b0);
      coolant_valid_i <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         elec_load_i <= 3'h1 << k;
         eff(16'h0016, 1'b0);
      end
      elec_load_i <= 3'h0;
      batt_mv_i <= 16'h2edf;
      eff(16'h0018, 1'b0);
      batt_mv_i <= 16'h2ee0;
      eff(16'h0010, 1'b0);
      ac_on_i <= 1'b1;
      wr(isec_pkg::REG_MAX, 16'h0014);
      eff(16'h0014, 1'b0);
      ac_on_i <= 1'b0;
      wr(isec_pkg::REG_MAX, 16'h0064);
      wr(isec_pkg::REG_MIN, 16'h001e);
      eff(16'h001e, 1'b0);
      wr(isec_pkg::REG_MIN, 16'h0000);
      air_temp_i <= 8'sh04;
      wr(isec_pkg::REG_AIRCORR, 16'h0040);
      wr(isec_pkg::REG_CTRL, 16'h0008);
      eff(16'h0020, 1'b0);
      wr(isec_pkg::REG_CTRL, 16'h0001);
      engine_stopped_i <= 1'b1;
      eff(16'h00c8, 1'b0);
      chk("valve_duty", 16'h00c8, duty);
      chk("stepper", 16'h000c, {12'h000, stepper_o});
      wr(isec_pkg::REG_CTRL, 16'h0003);
      eff(16'h00c8, 1'b0);
      chk("stepper", 16'h0001, {12'h000, stepper_o});
      stop_test();
   end
endmodule // isec_top_bench
